// file: core/dbr_pkg.sv
/*
  Shared constants, command codes and helper functions for the DRAM
  command link between the memory controller end and the device end.
  Assumes both ends run on MCLK at 10 MHz and that the controller makes
  the link clock.
*/
package dbr_pkg;
  // System clock and link clock
  localparam int MCLK_PERIOD_NS = 100;
  localparam int CK_HALF_CYCLES = 4;        // Link clock 800 ns period
  // Refresh timing
  localparam int AVG_REFRESH_INTERVAL_NS = 7800;
  localparam int REFRESH_CYCLE_TIME_NS = 260;
  localparam int REFRESH_POSTPONE_MAX = 9;
  localparam int REFI_CYCLES = AVG_REFRESH_INTERVAL_NS / MCLK_PERIOD_NS;
  localparam int REFI_MAX_CYCLES = REFRESH_POSTPONE_MAX * REFI_CYCLES;
  localparam int RFC_CYCLES = (REFRESH_CYCLE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int REF_GUARD_CYCLES = 4 * CK_HALF_CYCLES * 4;
  // Link widths
  localparam int ADDR_W = 13;
  localparam int COL_W = 6;
  localparam int A12_POS = 12;
  // Mode register zero field positions
  localparam int MR_BURST_LSB = 0;
  localparam int MR_CL_LSB = 2;
  localparam int MR_AL_LSB = 6;
  localparam int MR_CWL_LSB = 8;
  // Burst field encodings
  localparam logic [1:0] BURST_FULL = 2'h0;
  localparam logic [1:0] BURST_OTF = 2'h1;
  localparam logic [1:0] BURST_CHOP = 2'h2;
  // Additive latency selections
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;
  // Reset values of mode register zero
  localparam logic [1:0] MR_BURST_RST = 2'h0;
  localparam logic [3:0] MR_CL_RST = 4'h5;
  localparam logic [1:0] MR_AL_RST = 2'h0;
  localparam logic [3:0] MR_CWL_RST = 4'h5;
  // Burst lengths in beats
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;

  // Commands on the link
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_MRS = 3'b001,
    CMD_REF = 3'b010,
    CMD_RD = 3'b011,
    CMD_WR = 3'b100,
    CMD_PDE = 3'b101,
    CMD_PDX = 3'b110
  } dbr_cmd_t;

  // Chopped burst when fixed chop, or on-the-fly with A12 low
  function automatic logic dbr_is_chop(input logic [1:0] burst, input logic a12);
    dbr_is_chop = (burst == BURST_CHOP) || ((burst == BURST_OTF) && !a12);
  endfunction

  // Additive latency from its selection
  function automatic logic [4:0] dbr_add_lat(input logic [3:0] cl, input logic [1:0] al);
    case (al)
      AL_CL_M1: dbr_add_lat = {1'b0, cl} - 5'h01;
      AL_CL_M2: dbr_add_lat = {1'b0, cl} - 5'h02;
      default: dbr_add_lat = 5'h00;
    endcase
  endfunction

  // Termination window in precharge power-down: write latency less one
  function automatic logic [4:0] dbr_term_window(input logic [3:0] cas_write_latency, input logic [4:0] al);
    dbr_term_window = {1'b0, cas_write_latency} + al - 5'h01;
  endfunction
endpackage

// file: core/dbr_link_if.sv
/*
  Link between controller end and device end.
  Assumes the testbench joins both ends; dq resolves from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbr_link_if;
  logic ck;
  logic [2:0] cmd;
  logic [12:0] addr;
  logic odt;
  logic [7:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [7:0] dev_dq_o;
  logic dev_dq_oe;
  logic [7:0] dq;

  // Wire level of the shared data pins; undriven reads as zero
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : 8'h00);

  modport dev (input ck, input cmd, input addr, input odt, input dq,
               output dev_dq_o, output dev_dq_oe);
  modport ctl (output ck, output cmd, output addr, output odt, input dq,
               output ctl_dq_o, output ctl_dq_oe);
endinterface
`default_nettype wire

// file: core/dbr_device.sv
/*
  Device end of the DRAM command link: decodes commands on sampled link
  clock rises, holds mode register zero, runs read and write bursts into
  a small array, and times termination in precharge power-down.
  Assumes the controller keeps refresh and spacing rules.
*/
`timescale 1ns/1ps
`default_nettype none
module dbr_device
  import dbr_pkg::*;
(
  // System
  input wire logic MCLK,
  input wire logic RESET_N,
  // Link
  dbr_link_if.dev LINK,
  // Status
  output logic TERM_ON,
  output logic POWER_DOWN,
  output logic LAST_CHOP,
  output logic REFRESH_SEEN
);
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_WAIT = 2'b01,
    DS_BURST = 2'b10
  } dbr_dstate_t;

  // Synchronisers for every link input
  logic ck_s1_ff, ck_s2_ff, ck_prev_ff;
  logic [2:0] cmd_s1_ff, cmd_s2_ff;
  logic [ADDR_W-1:0] addr_s1_ff, addr_s2_ff;
  logic odt_s1_ff, odt_s2_ff;
  logic [7:0] dq_s1_ff, dq_s2_ff;

  // Input stage: two flops, then edge detect on the second only
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ck_s1_ff <= 1'b0;
      ck_s2_ff <= 1'b0;
      ck_prev_ff <= 1'b0;
      cmd_s1_ff <= 3'h0;
      cmd_s2_ff <= 3'h0;
      addr_s1_ff <= 13'h0000;
      addr_s2_ff <= 13'h0000;
      odt_s1_ff <= 1'b0;
      odt_s2_ff <= 1'b0;
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      ck_s1_ff <= LINK.ck;
      ck_s2_ff <= ck_s1_ff;
      ck_prev_ff <= ck_s2_ff;
      cmd_s1_ff <= LINK.cmd;
      cmd_s2_ff <= cmd_s1_ff;
      addr_s1_ff <= LINK.addr;
      addr_s2_ff <= addr_s1_ff;
      odt_s1_ff <= LINK.odt;
      odt_s2_ff <= odt_s1_ff;
      dq_s1_ff <= LINK.dq;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  logic ck_rise;
  dbr_cmd_t cmd_in;
  assign ck_rise = ck_s2_ff && !ck_prev_ff;
  assign cmd_in = dbr_cmd_t'(cmd_s2_ff);

  // Mode register zero and burst state
  logic [1:0] burst_ff, nxt_burst;
  logic [3:0] cl_ff, nxt_cl;
  logic [1:0] al_ff, nxt_al;
  logic [3:0] cwl_ff, nxt_cwl;
  dbr_dstate_t st_ff, nxt_st;
  logic is_rd_ff, nxt_is_rd;
  logic [4:0] lat_ff, nxt_lat;
  logic [3:0] beats_ff, nxt_beats;
  logic [COL_W-1:0] col_ff, nxt_col;
  logic chop_ff, nxt_chop;
  logic [7:0] dq_o_ff, nxt_dq_o;
  logic dq_oe_ff, nxt_dq_oe;
  logic pd_ff, nxt_pd;
  logic term_ff, nxt_term;
  logic [4:0] tcnt_ff, nxt_tcnt;
  logic ref_ff, nxt_ref;
  logic [7:0] mem [0:(1<<COL_W)-1];
  logic mem_we;
  logic [COL_W-1:0] mem_addr;
  logic [4:0] al_cyc, window;

  assign al_cyc = dbr_add_lat(cl_ff, al_ff);
  assign window = dbr_term_window(cwl_ff, al_cyc);

  // Command decode, burst sequencing and termination timing
  always_comb begin
    nxt_burst = burst_ff;
    nxt_cl = cl_ff;
    nxt_al = al_ff;
    nxt_cwl = cwl_ff;
    nxt_st = st_ff;
    nxt_is_rd = is_rd_ff;
    nxt_lat = lat_ff;
    nxt_beats = beats_ff;
    nxt_col = col_ff;
    nxt_chop = chop_ff;
    nxt_dq_o = dq_o_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_pd = pd_ff;
    nxt_term = term_ff;
    nxt_tcnt = tcnt_ff;
    nxt_ref = 1'b0;
    mem_we = 1'b0;
    mem_addr = col_ff;
    if (ck_rise) begin
      case (st_ff)
        DS_IDLE: begin
          case (cmd_in)
            CMD_MRS: begin
              nxt_burst = addr_s2_ff[MR_BURST_LSB +: 2];
              nxt_cl = addr_s2_ff[MR_CL_LSB +: 4];
              nxt_al = addr_s2_ff[MR_AL_LSB +: 2];
              nxt_cwl = addr_s2_ff[MR_CWL_LSB +: 4];
            end
            CMD_RD, CMD_WR: begin
              // Burst kind fixed now from field and this command's A12
              nxt_chop = dbr_is_chop(burst_ff, addr_s2_ff[A12_POS]);
              nxt_beats = nxt_chop ? BEATS_CHOP : BEATS_FULL;
              nxt_col = addr_s2_ff[COL_W-1:0];
              nxt_is_rd = (cmd_in == CMD_RD);
              // Read latency is CL plus AL; write latency is CAS_WRITE_LATENCY plus AL
              nxt_lat = (cmd_in == CMD_RD) ? ({1'b0, cl_ff} + al_cyc)
                                           : ({1'b0, cwl_ff} + al_cyc);
              nxt_st = DS_WAIT;
            end
            CMD_REF: nxt_ref = 1'b1;  // Idle is guaranteed by the controller
            CMD_PDE: nxt_pd = 1'b1;
            CMD_PDX: nxt_pd = 1'b0;
            default: ;
          endcase
        end
        DS_WAIT: begin
          nxt_lat = lat_ff - 5'h01;
          if (lat_ff == 5'h01) begin
            nxt_st = DS_BURST;
            if (is_rd_ff) begin
              nxt_dq_o = mem[col_ff];
              nxt_dq_oe = 1'b1;
            end else begin
              mem_we = 1'b1;
            end
          end
        end
        DS_BURST: begin
          nxt_beats = beats_ff - 4'h1;
          nxt_col = col_ff + 6'h01;
          if (beats_ff == 4'h1) begin
            nxt_st = DS_IDLE;
            nxt_dq_oe = 1'b0;
          end else if (is_rd_ff) begin
            nxt_dq_o = mem[nxt_col];
          end else begin
            // Later write beats land on the advanced column, not the first one again
            mem_addr = nxt_col;
            mem_we = 1'b1;
          end
        end
        default: nxt_st = DS_IDLE;
      endcase
      // Termination: follows ODT directly when awake, after the window in power-down
      if (!pd_ff) begin
        nxt_term = odt_s2_ff;
        nxt_tcnt = 5'h00;
      end else if (odt_s2_ff != term_ff) begin
        nxt_tcnt = tcnt_ff + 5'h01;
        // Sampling rise first, then the full window of rises
        if (tcnt_ff + 5'h01 > window) begin
          nxt_term = odt_s2_ff;
          nxt_tcnt = 5'h00;
        end
      end else begin
        nxt_tcnt = 5'h00;
      end
    end
  end

  // Register stage
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      burst_ff <= MR_BURST_RST;
      cl_ff <= MR_CL_RST;
      al_ff <= MR_AL_RST;
      cwl_ff <= MR_CWL_RST;
      st_ff <= DS_IDLE;
      is_rd_ff <= 1'b0;
      lat_ff <= 5'h00;
      beats_ff <= 4'h0;
      col_ff <= 6'h00;
      chop_ff <= 1'b0;
      dq_o_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
      pd_ff <= 1'b0;
      term_ff <= 1'b0;
      tcnt_ff <= 5'h00;
      ref_ff <= 1'b0;
    end else begin
      burst_ff <= nxt_burst;
      cl_ff <= nxt_cl;
      al_ff <= nxt_al;
      cwl_ff <= nxt_cwl;
      st_ff <= nxt_st;
      is_rd_ff <= nxt_is_rd;
      lat_ff <= nxt_lat;
      beats_ff <= nxt_beats;
      col_ff <= nxt_col;
      chop_ff <= nxt_chop;
      dq_o_ff <= nxt_dq_o;
      dq_oe_ff <= nxt_dq_oe;
      pd_ff <= nxt_pd;
      term_ff <= nxt_term;
      tcnt_ff <= nxt_tcnt;
      ref_ff <= nxt_ref;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge MCLK) begin
    if (mem_we) begin
      mem[mem_addr] <= dq_s2_ff;
    end
  end

  assign LINK.dev_dq_o = dq_o_ff;
  assign LINK.dev_dq_oe = dq_oe_ff;
  assign TERM_ON = term_ff;
  assign POWER_DOWN = pd_ff;
  assign LAST_CHOP = chop_ff;
  assign REFRESH_SEEN = ref_ff;
endmodule
`default_nettype wire

// file: core/dbr_ctrl.sv
/*
  Controller end: makes the link clock by division, issues one command per
  link clock, enforces refresh spacing and recovery, moves burst data.
  Assumes the device samples commands on link clock rises.
*/
`timescale 1ns/1ps
`default_nettype none
module dbr_ctrl
  import dbr_pkg::*;
(
  // System
  input wire logic MCLK,
  input wire logic RESET_N,
  // Request
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [2:0] REQ_CMD,
  input wire logic [12:0] REQ_ADDR,
  input wire logic REQ_ODT,
  // Write data, one beat per WR_TAKE pulse
  input wire logic [7:0] WR_DATA,
  output logic WR_TAKE,
  // Read data
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  // Link
  dbr_link_if.ctl LINK
);
  logic [2:0] div_ff, nxt_div;
  logic ck_ff, nxt_ck;
  logic [2:0] cmd_ff, nxt_cmd;
  logic [12:0] addr_ff, nxt_addr;
  logic odt_ff, nxt_odt;
  logic [1:0] burst_ff, nxt_burst;
  logic [4:0] rl_ff, nxt_rl, wl_ff, nxt_wl;
  logic [5:0] busy_ff, nxt_busy;
  logic [5:0] dcnt_ff, nxt_dcnt;
  logic [3:0] beats_ff, nxt_beats;
  logic is_rd_ff, nxt_is_rd;
  logic [9:0] refi_ff, nxt_refi;
  logic [7:0] rfc_ff, nxt_rfc;
  logic [7:0] dq_o_ff, nxt_dq_o;
  logic dq_oe_ff, nxt_dq_oe;
  logic [7:0] rd_ff, nxt_rd;
  logic rdv_ff, nxt_rdv;
  logic [7:0] dq_s1_ff, dq_s2_ff;
  logic rise, fall, idle, force_ref, take;
  logic [4:0] al_n;
  logic burst_req, burst_late;
  logic [5:0] burst_cost;
  logic [10:0] burst_end;

  assign rise = (div_ff == 3'(CK_HALF_CYCLES - 1)) && !ck_ff;
  assign fall = (div_ff == 3'(CK_HALF_CYCLES - 1)) && ck_ff;
  // Idle means no burst or power-down exit hold-off in flight and refresh recovery over
  assign idle = (busy_ff == 6'h00) && (rfc_ff == 8'h00);
  assign force_ref = refi_ff >= 10'(REFI_MAX_CYCLES - REF_GUARD_CYCLES);
  // A burst that would still run when refresh falls due is held back
  assign burst_req = (REQ_CMD == CMD_RD) || (REQ_CMD == CMD_WR);
  assign burst_cost = {1'b0, (REQ_CMD == CMD_RD) ? rl_ff : wl_ff} + 6'h0b;
  // Cost in system clocks: eight per link clock
  assign burst_end = {1'b0, refi_ff} + {2'b00, burst_cost, 3'b000};
  assign burst_late = burst_req && (burst_end >= 11'(REFI_MAX_CYCLES - REF_GUARD_CYCLES));
  assign REQ_READY = fall && idle && !force_ref && !burst_late;
  assign take = REQ_VALID && REQ_READY;
  assign al_n = dbr_add_lat(REQ_ADDR[MR_CL_LSB +: 4], REQ_ADDR[MR_AL_LSB +: 2]);

  // Divider, command issue, refresh bookkeeping and data beats
  always_comb begin
    nxt_div = div_ff + 3'h1;
    nxt_ck = ck_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_odt = odt_ff;
    nxt_burst = burst_ff;
    nxt_rl = rl_ff;
    nxt_wl = wl_ff;
    nxt_busy = busy_ff;
    nxt_dcnt = dcnt_ff;
    nxt_beats = beats_ff;
    nxt_is_rd = is_rd_ff;
    nxt_refi = (refi_ff == 10'h3ff) ? refi_ff : refi_ff + 10'h001;
    nxt_rfc = (rfc_ff == 8'h00) ? rfc_ff : rfc_ff - 8'h01;
    nxt_dq_o = dq_o_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_rd = rd_ff;
    nxt_rdv = 1'b0;
    WR_TAKE = 1'b0;
    if (div_ff == 3'(CK_HALF_CYCLES - 1)) begin
      nxt_div = 3'h0;
      nxt_ck = !ck_ff;
    end
    // Commands change on the falling edge so they are steady at the rise
    if (fall) begin
      nxt_cmd = CMD_NOP;  // Only NOP while refresh recovery runs
      if (idle && force_ref) begin
        nxt_cmd = CMD_REF;  // Issued only when idle, before nine intervals pass
        nxt_refi = 10'h000;
        nxt_rfc = 8'(RFC_CYCLES);
      end else if (take) begin
        nxt_cmd = REQ_CMD;
        nxt_addr = REQ_ADDR;
        nxt_odt = REQ_ODT;
        case (dbr_cmd_t'(REQ_CMD))
          CMD_MRS: begin
            nxt_burst = REQ_ADDR[MR_BURST_LSB +: 2];
            nxt_rl = {1'b0, REQ_ADDR[MR_CL_LSB +: 4]} + al_n;
            nxt_wl = {1'b0, REQ_ADDR[MR_CWL_LSB +: 4]} + al_n;
          end
          CMD_REF: begin
            nxt_refi = 10'h000;
            nxt_rfc = 8'(RFC_CYCLES);
          end
          CMD_RD, CMD_WR: begin
            // Same burst choice as the device makes for this command
            nxt_beats = dbr_is_chop(burst_ff, REQ_ADDR[A12_POS]) ? BEATS_CHOP : BEATS_FULL;
            nxt_is_rd = (REQ_CMD == CMD_RD);
            nxt_dcnt = 6'h00;
            nxt_busy = (REQ_CMD == CMD_RD) ? {1'b0, rl_ff} + 6'h0a : {1'b0, wl_ff} + 6'h0a;
          end
          CMD_PDX: begin
            // Hold off new commands for the power-down termination window
            nxt_busy = {1'b0, wl_ff};
          end
          default: ;
        endcase
      end
      // Write beats are driven at the fall before the device samples them
      if (!is_rd_ff && busy_ff != 6'h00) begin
        // Device stores from the rise WL after the one that took the command
        if (dcnt_ff >= {1'b0, wl_ff} && dcnt_ff < {1'b0, wl_ff} + {2'b00, beats_ff}) begin
          nxt_dq_o = WR_DATA;
          nxt_dq_oe = 1'b1;
          WR_TAKE = 1'b1;
        end else begin
          nxt_dq_oe = 1'b0;
        end
      end
    end
    if (rise) begin
      if (busy_ff != 6'h00) begin
        nxt_busy = busy_ff - 6'h01;
        nxt_dcnt = dcnt_ff + 6'h01;
        // Read beats land one link clock after the device drives them
        if (is_rd_ff && dcnt_ff >= {1'b0, rl_ff} + 6'h01
            && dcnt_ff < {1'b0, rl_ff} + 6'h01 + {2'b00, beats_ff}) begin
          nxt_rd = dq_s2_ff;
          nxt_rdv = 1'b1;
        end
      end
    end
  end

  // Register stage, with a two-flop input stage on the data pins
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      div_ff <= 3'h0;
      ck_ff <= 1'b0;
      cmd_ff <= CMD_NOP;
      addr_ff <= 13'h0000;
      odt_ff <= 1'b0;
      burst_ff <= MR_BURST_RST;
      rl_ff <= {1'b0, MR_CL_RST};
      wl_ff <= {1'b0, MR_CWL_RST};
      busy_ff <= 6'h00;
      dcnt_ff <= 6'h00;
      beats_ff <= 4'h0;
      is_rd_ff <= 1'b0;
      refi_ff <= 10'h000;
      rfc_ff <= 8'h00;
      dq_o_ff <= 8'h00;
      dq_oe_ff <= 1'b0;
      rd_ff <= 8'h00;
      rdv_ff <= 1'b0;
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      div_ff <= nxt_div;
      ck_ff <= nxt_ck;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      odt_ff <= nxt_odt;
      burst_ff <= nxt_burst;
      rl_ff <= nxt_rl;
      wl_ff <= nxt_wl;
      busy_ff <= nxt_busy;
      dcnt_ff <= nxt_dcnt;
      beats_ff <= nxt_beats;
      is_rd_ff <= nxt_is_rd;
      refi_ff <= nxt_refi;
      rfc_ff <= nxt_rfc;
      dq_o_ff <= nxt_dq_o;
      dq_oe_ff <= nxt_dq_oe;
      rd_ff <= nxt_rd;
      rdv_ff <= nxt_rdv;
      dq_s1_ff <= LINK.dq;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  assign LINK.ck = ck_ff;
  assign LINK.cmd = cmd_ff;
  assign LINK.addr = addr_ff;
  assign LINK.odt = odt_ff;
  assign LINK.ctl_dq_o = dq_o_ff;
  assign LINK.ctl_dq_oe = dq_oe_ff;
  assign RD_DATA = rd_ff;
  assign RD_VALID = rdv_ff;
endmodule
`default_nettype wire

// file: testbench/dbr_link_sva.sv
/*
  Checker for the DRAM command link: command framing on the link clock,
  refresh spacing and recovery, read start and burst length.
  Assumes the testbench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
module dbr_link_sva
  import dbr_pkg::*;
(
  // System
  input wire logic MCLK,
  input wire logic RESET_N,
  // Link
  input wire logic ck,
  input wire logic [2:0] cmd,
  input wire logic [12:0] addr,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe
);
  logic ck_ff;
  logic [1:0] burst_ff;
  logic [3:0] cl_ff;
  logic [1:0] al_ff;
  logic chop_ff;
  logic [15:0] ref_age_ff;
  logic [4:0] rises_ff;
  logic [7:0] oe_len_ff;
  logic nxt_ck;
  logic [1:0] nxt_burst;
  logic [3:0] nxt_cl;
  logic [1:0] nxt_al;
  logic nxt_chop;
  logic [15:0] nxt_ref_age;
  logic [4:0] nxt_rises;
  logic [7:0] nxt_oe_len;
  logic new_cmd;
  logic [3:0] al_amt;
  logic [4:0] rl;

  // Shadow of the mode register and counters; commands are new at a link clock fall
  always_comb begin
    new_cmd = ck_ff && !ck;
    nxt_ck = ck;
    nxt_burst = burst_ff;
    nxt_cl = cl_ff;
    nxt_al = al_ff;
    nxt_chop = chop_ff;
    nxt_ref_age = (ref_age_ff == 16'hffff) ? ref_age_ff : ref_age_ff + 16'h0001;
    nxt_rises = (ck && !ck_ff && rises_ff != 5'h1f) ? rises_ff + 5'h01 : rises_ff;
    nxt_oe_len = !dev_dq_oe ? 8'h00 : (oe_len_ff == 8'hff) ? oe_len_ff : oe_len_ff + 8'h01;
    al_amt = (al_ff == AL_CL_M1) ? cl_ff - 4'h1 : (al_ff == AL_CL_M2) ? cl_ff - 4'h2 : 4'h0;
    rl = {1'b0, cl_ff} + {1'b0, al_amt};
    if (new_cmd && cmd == CMD_MRS) begin
      nxt_burst = addr[1:0];
      nxt_cl = addr[5:2];
      nxt_al = addr[7:6];
    end
    if (new_cmd && cmd == CMD_REF) nxt_ref_age = 16'h0000;
    if (new_cmd && cmd == CMD_RD) nxt_rises = 5'h00;
    if (new_cmd && (cmd == CMD_RD || cmd == CMD_WR)) begin
      nxt_chop = (burst_ff == BURST_CHOP) || (burst_ff == BURST_OTF && !addr[A12_POS]);
    end
  end

  // Registers only; reset values match the device's mode after reset
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ck_ff <= 1'b0;
      burst_ff <= MR_BURST_RST;
      cl_ff <= MR_CL_RST;
      al_ff <= MR_AL_RST;
      chop_ff <= 1'b0;
      ref_age_ff <= 16'h0000;
      rises_ff <= 5'h1f;
      oe_len_ff <= 8'h00;
    end else begin
      ck_ff <= nxt_ck;
      burst_ff <= nxt_burst;
      cl_ff <= nxt_cl;
      al_ff <= nxt_al;
      chop_ff <= nxt_chop;
      ref_age_ff <= nxt_ref_age;
      rises_ff <= nxt_rises;
      oe_len_ff <= nxt_oe_len;
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  // A link clock high phase lasts four system clocks
  sequence s_ck_high;
    ck [*4];
  endsequence
  sequence s_ck_drop;
    !ck;
  endsequence

  a_ck_high_phase: assert property ($rose(ck) |-> s_ck_high ##1 s_ck_drop)
    else $error("link clock high phase is not four cycles");
  a_cmd_on_fall: assert property ($changed(cmd) |-> $fell(ck))
    else $error("command changed away from a link clock fall");
  a_cmd_stands: assert property ($changed(cmd) |=> $stable(cmd) [*7])
    else $error("command did not stand a full link period");
  a_ref_recovery: assert property ($changed(cmd) && cmd != CMD_NOP |-> ref_age_ff >= RFC_CYCLES)
    else $error("command inside refresh recovery time");
  a_ref_idle: assert property (new_cmd && cmd == CMD_REF |-> !dev_dq_oe && !ctl_dq_oe)
    else $error("refresh issued with a burst on the data pins");
  a_ref_gap: assert property (ref_age_ff <= REFI_MAX_CYCLES)
    else $error("refresh gap exceeds nine average intervals");
  a_read_start: assert property ($rose(dev_dq_oe) |-> rises_ff == rl + 5'h01)
    else $error("read data did not start at the read latency");
  a_burst_len: assert property ($fell(dev_dq_oe) |-> chop_ff ?
    (oe_len_ff inside {[8'h1f:8'h21]}) : (oe_len_ff inside {[8'h3f:8'h41]}))
    else $error("read burst length does not match burst setting");
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
/*
  Testbench joining controller and device ends over the link interface.
  Drives the request side of the controller and checks returned data,
  device status and termination timing against a byte model.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import dbr_pkg::*;
();
  logic mclk;
  logic reset_n;
  logic req_valid;
  logic req_ready;
  logic [2:0] req_cmd;
  logic [12:0] req_addr;
  logic req_odt;
  logic [7:0] wr_data;
  logic wr_take;
  logic [7:0] rd_data;
  logic rd_valid;
  logic term_on;
  logic power_down;
  logic last_chop;
  logic refresh_seen;
  logic [7:0] mem [64];
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [1:0] BT [3] = '{BURST_FULL, BURST_CHOP, BURST_OTF};

  dbr_link_if link ();
  dbr_ctrl dbr_ctrl_inst (.MCLK(mclk), .RESET_N(reset_n), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr), .REQ_ODT(req_odt),
    .WR_DATA(wr_data), .WR_TAKE(wr_take), .RD_DATA(rd_data), .RD_VALID(rd_valid), .LINK(link));
  dbr_device dbr_device_inst (.MCLK(mclk), .RESET_N(reset_n), .LINK(link), .TERM_ON(term_on),
    .POWER_DOWN(power_down), .LAST_CHOP(last_chop), .REFRESH_SEEN(refresh_seen));
  dbr_link_sva dbr_link_sva_inst (.MCLK(mclk), .RESET_N(reset_n), .ck(link.ck), .cmd(link.cmd),
    .addr(link.addr), .ctl_dq_oe(link.ctl_dq_oe), .dev_dq_oe(link.dev_dq_oe));

  // System clock
  always #(MCLK_PERIOD_NS / 2) mclk = ~mclk;

  // Next write byte once the controller has taken the current one
  always @(posedge mclk) begin
    if (wr_take === 1'b1) wr_data <= wr_data + 8'h11;
  end

  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One request, held until the controller takes it; a gap edge follows
  task automatic issue(input logic [2:0] c, input logic [12:0] a, input logic o);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_odt <= o;
    @(posedge mclk);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    `CHK("req_taken", 1'b1, req_ready)
    req_valid <= 1'b0;
    @(posedge mclk);
  endtask

  // Write a burst of consecutive columns and record it in the model
  task automatic wr(input logic [5:0] col, input logic a12, input int beats,
                    input logic [7:0] seed);
    wr_data <= seed;
    for (int k = 0; k < beats; k++) mem[col + k] = 8'(seed + 8'h11 * k);
    issue(CMD_WR, {a12, 6'h00, col}, 1'b0);
  endtask

  // Read a burst; every returned beat is compared, then the beat count
  task automatic rd(input logic [5:0] col, input logic a12, input int beats);
    int got;
    got = 0;
    issue(CMD_RD, {a12, 6'h00, col}, 1'b0);
    repeat (300) begin
      @(posedge mclk);
      if (rd_valid === 1'b1) begin
        `CHK("rd_data", mem[col + got], rd_data)
        got++;
      end
    end
    `CHK("beats", beats, got)
  endtask

  // Count refresh pulses over a fixed span
  task automatic count_refresh(input int cycles, input int exp_n);
    int cnt;
    cnt = 0;
    repeat (cycles) begin
      @(posedge mclk);
      if (refresh_seen === 1'b1) cnt++;
    end
    `CHK("refresh_count", exp_n, cnt)
  endtask

  // Link clock rises until termination reaches the level
  task automatic term_rises(input logic lvl, input int exp_r);
    int r;
    int n;
    logic ck_q;
    r = 0;
    n = 0;
    ck_q = link.ck;
    while (term_on !== lvl && n < 600) begin
      @(posedge mclk);
      n++;
      if (link.ck === 1'b1 && ck_q === 1'b0) r++;
      ck_q = link.ck;
    end
    `CHK("term_rises", exp_r, r)
  endtask

  initial begin
    logic a12;
    int beats;
    mclk = 1'b0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    req_addr = 13'h0000;
    req_odt = 1'b0;
    wr_data = 8'h00;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    // Each burst setting with both A12 levels; latencies vary per pass
    for (int i = 0; i < 6; i++) begin
      a12 = 1'(i % 2);
      beats = (BT[i / 2] == BURST_CHOP || (BT[i / 2] == BURST_OTF && !a12)) ? 4 : 8;
      issue(CMD_MRS, {1'b0, 4'h5, 2'(i % 3), 4'(5 + i % 2), BT[i / 2]}, 1'b0);
      wr(6'(i * 8), a12, beats, 8'(8'h10 * i + 1));
      rd(6'(i * 8), a12, beats);
      `CHK("last_chop", beats == 4, last_chop)
    end
    // Refresh requested while a write burst is still moving, then read back
    wr(6'h30, 1'b1, 8, 8'hc3);
    issue(CMD_REF, 13'h0000, 1'b0);
    count_refresh(400, 1);
    rd(6'h30, 1'b1, 8);
    // Left idle, the controller must refresh on its own before the limit
    count_refresh(REFI_MAX_CYCLES + 40, 1);
    // Termination awake follows at the sampling rise, in power-down WL-1 later
    issue(CMD_MRS, {1'b0, 4'h5, AL_ZERO, 4'h5, BURST_FULL}, 1'b0);
    issue(CMD_NOP, 13'h0000, 1'b1);
    term_rises(1'b1, 1);
    issue(CMD_NOP, 13'h0000, 1'b0);
    term_rises(1'b0, 1);
    issue(CMD_PDE, 13'h0000, 1'b0);
    repeat (24) @(posedge mclk);
    `CHK("power_down", 1'b1, power_down)
    issue(CMD_NOP, 13'h0000, 1'b1);
    term_rises(1'b1, 1 + (5 - 1));
    issue(CMD_PDX, 13'h0000, 1'b0);
    repeat (64) @(posedge mclk);
    `CHK("power_down", 1'b0, power_down)
    final_report();
  end

  // Watchdog: the sequence needs under 10000 cycles, so three times that is a hang
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
